// ===== rtl/port0_pkg.sv
// constants for the port 0 pin function block
// Overview of operation
// - output direction in port mode drives the pin from its output latch
// - data read of an output pin returns the output latch
// - data write to an input pin only updates the latch
// - data read of an input pin returns the sampled pin level
// - latch bits hold their value until software writes them again
// - data register access depends on direction only, not on mode
// - one bit per pin, each bit individually readable and writable
// - direction bit 0 is output, 1 is input, per pin
// - mode bit 0 is port, 1 is alternate; mode register resets to zero
// - function-select bit picks one of two alternate functions; here it is only stored and read back, no routing uses it
// - extension bit joins function-select for three or more functions; this block has no extension register
// - open-drain bit 0 is push-pull, 1 is n-channel open drain
// - open-drain bit acts only in port mode output direction
// - 66 pins; mode, extension registers exist only on listed ports
// - port 0 has five pins, bits 2 to 6, each with own direction
// - alternate routing: nmi, irq0 plus trigger, irq1 to irq3
// - debug enable set makes pin 5 the debug reset input
package port0_pkg;
    localparam logic [2:0] data_off      = 3'h0;
    localparam logic [2:0] dir_off       = 3'h1;
    localparam logic [2:0] mode_off      = 3'h2;
    localparam logic [2:0] fsel_off      = 3'h3;
    localparam logic [2:0] od_off        = 3'h4;
    localparam logic [2:0] dbg_off       = 3'h5;
    localparam logic [7:0] pin_mask      = 8'h7c;
    localparam logic [7:0] data_reset    = 8'h00;
    localparam logic [7:0] dir_reset     = 8'hff;
    localparam logic [7:0] mode_reset    = 8'h00;
    localparam logic [7:0] fsel_reset    = 8'h00;
    localparam logic [7:0] od_reset      = 8'h00;
    localparam logic       dbg_reset     = 1'b1;
    localparam int         nmi_bit       = 2;
    localparam int         irq0_bit      = 3;
    localparam int         irq1_bit      = 4;
    localparam int         irq2_bit      = 5;
    localparam int         irq3_bit      = 6;
    localparam int         dbg_rst_bit   = 5;
endpackage

// ===== rtl/port0_pin_function_control.sv
// port 0 pin function control: latch, direction, mode, open drain
`timescale 1ns/1ps
`default_nettype none
module port0_pin_function_control (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic [7:0] pin_in,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe_n,
    output logic            nmi_in,
    output logic            ext_irq_in_0,
    output logic            converter_trigger_in,
    output logic            ext_irq_in_1,
    output logic            ext_irq_in_2,
    output logic            ext_irq_in_3,
    output logic            debug_reset_in
);
    logic [7:0] port_data_latch;
    logic [7:0] port_direction;
    logic [7:0] port_alt_mode_select;
    logic [7:0] alt_function_select;
    logic [7:0] open_drain_select;
    logic       debug_enable_bit;

    // values the registers take at the next edge
    logic [7:0] next_port_data_latch;
    logic [7:0] next_port_direction;
    logic [7:0] next_port_alt_mode_select;
    logic [7:0] next_alt_function_select;
    logic [7:0] next_open_drain_select;
    logic       next_debug_enable_bit;

    // one write strobe per register index
    logic       wr_data;
    logic       wr_dir;
    logic       wr_mode;
    logic       wr_fsel;
    logic       wr_od;
    logic       wr_dbg;

    logic [7:0] next_rdata_bit_sel;
    logic [7:0] next_rdata;
    logic [7:0] next_rdata_out;
    logic [7:0] drive_en;
    logic [7:0] od_active;

    // routed alternate inputs before their flops
    logic       next_nmi_in;
    logic       next_ext_irq_in_0;
    logic       next_converter_trigger_in;
    logic       next_ext_irq_in_1;
    logic       next_ext_irq_in_2;
    logic       next_ext_irq_in_3;
    logic       next_debug_reset_in;

    function automatic logic [7:0] masked(input logic [7:0] v);
        masked = v & port0_pkg::pin_mask;
    endfunction

    // register write strobe for one index
    function automatic logic write_hit(
        input logic       we,
        input logic [2:0] a,
        input logic [2:0] off
    );
        write_hit = we && (a == off);
    endfunction

    // alternate input: pin level only while mode bit is set
    function automatic logic routed(
        input logic sel,
        input logic lvl
    );
        routed = sel & lvl;
    endfunction

    // pin driven in port mode with output direction
    function automatic logic pin_drives(
        input logic used,
        input logic alt,
        input logic dir
    );
        pin_drives = used & ~alt & ~dir;
    endfunction

    // extension and select pair to function index 0..3
    function automatic logic [1:0] alt_index(
        input logic ext,
        input logic sel
    );
        alt_index = {ext, sel};
    endfunction

    // one write strobe per register index
    assign wr_data = write_hit(wr, addr, port0_pkg::data_off);
    assign wr_dir  = write_hit(wr, addr, port0_pkg::dir_off);
    assign wr_mode = write_hit(wr, addr, port0_pkg::mode_off);
    assign wr_fsel = write_hit(wr, addr, port0_pkg::fsel_off);
    assign wr_od   = write_hit(wr, addr, port0_pkg::od_off);
    assign wr_dbg  = write_hit(wr, addr, port0_pkg::dbg_off);

    // output latch: kept until software writes it
    always_comb begin
        next_port_data_latch = port_data_latch;
        if (wr_data) begin
            next_port_data_latch = masked(wdata);
        end
    end

    // latch clears on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_data_latch <= port0_pkg::data_reset;
        end else begin
            port_data_latch <= next_port_data_latch;
        end
    end

    // spare bits stay input so they never drive
    always_comb begin
        next_port_direction = port_direction;
        if (wr_dir) begin
            next_port_direction = masked(wdata) | ~port0_pkg::pin_mask;
        end
    end

    // every pin starts as input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_direction <= port0_pkg::dir_reset;
        end else begin
            port_direction <= next_port_direction;
        end
    end

    // per-pin port or alternate select
    always_comb begin
        next_port_alt_mode_select = port_alt_mode_select;
        if (wr_mode) begin
            next_port_alt_mode_select = masked(wdata);
        end
    end

    // port mode on every pin after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_alt_mode_select <= port0_pkg::mode_reset;
        end else begin
            port_alt_mode_select <= next_port_alt_mode_select;
        end
    end

    // selects kept; port 0 alternates are single inputs
    always_comb begin
        next_alt_function_select = alt_function_select;
        if (wr_fsel) begin
            next_alt_function_select = masked(wdata);
        end
    end

    // function selects clear on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alt_function_select <= port0_pkg::fsel_reset;
        end else begin
            alt_function_select <= next_alt_function_select;
        end
    end

    // push-pull or open drain per pin
    always_comb begin
        next_open_drain_select = open_drain_select;
        if (wr_od) begin
            next_open_drain_select = masked(wdata);
        end
    end

    // push-pull after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            open_drain_select <= port0_pkg::od_reset;
        end else begin
            open_drain_select <= next_open_drain_select;
        end
    end

    // debug enable in bit 0 of its index
    always_comb begin
        next_debug_enable_bit = debug_enable_bit;
        if (wr_dbg) begin
            next_debug_enable_bit = wdata[0];
        end
    end

    // debug enable starts set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            debug_enable_bit <= port0_pkg::dbg_reset;
        end else begin
            debug_enable_bit <= next_debug_enable_bit;
        end
    end

    // per-pin readback: direction 0 latch, 1 pin level
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_read
            assign next_rdata_bit_sel[i] = port_direction[i] ?
                pin_in[i] : port_data_latch[i];
        end

        // port mode output only; port 0 alternates are inputs
        for (i = 0; i < 8; i++) begin : g_drive
            assign drive_en[i] = pin_drives(port0_pkg::pin_mask[i],
                port_alt_mode_select[i], port_direction[i]);
        end

        // open drain counts only on a driving pin
        for (i = 0; i < 8; i++) begin : g_od
            assign od_active[i] = drive_en[i] &
                open_drain_select[i];
        end

        // open drain drives low only, floats for one
        for (i = 0; i < 8; i++) begin : g_out
            assign pin_out[i] = od_active[i] ? 1'b0 :
                port_data_latch[i];
            assign pin_oe_n[i] = ~(drive_en[i] &
                (~od_active[i] | ~port_data_latch[i]));
        end
    endgenerate

    always_comb begin
        case (addr)
            port0_pkg::data_off: next_rdata = masked(next_rdata_bit_sel);
            port0_pkg::dir_off:  next_rdata = masked(port_direction);
            port0_pkg::mode_off: next_rdata = port_alt_mode_select;
            port0_pkg::fsel_off: next_rdata = alt_function_select;
            port0_pkg::od_off:   next_rdata = open_drain_select;
            port0_pkg::dbg_off:  next_rdata = {7'h00, debug_enable_bit};
            default:             next_rdata = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_comb begin
        next_rdata_out = 8'h00;
        if (rd) begin
            next_rdata_out = next_rdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata_out;
        end
    end

    // alternate routing; unselected inputs idle low
    // pin 2 feeds the nmi input
    always_comb begin
        next_nmi_in = routed(
            port_alt_mode_select[port0_pkg::nmi_bit],
            pin_in[port0_pkg::nmi_bit]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_in <= 1'b0;
        end else begin
            nmi_in <= next_nmi_in;
        end
    end

    // pin 3 feeds interrupt 0
    always_comb begin
        next_ext_irq_in_0 = routed(
            port_alt_mode_select[port0_pkg::irq0_bit],
            pin_in[port0_pkg::irq0_bit]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_irq_in_0 <= 1'b0;
        end else begin
            ext_irq_in_0 <= next_ext_irq_in_0;
        end
    end

    // pin 3 also feeds the converter trigger
    always_comb begin
        next_converter_trigger_in = routed(
            port_alt_mode_select[port0_pkg::irq0_bit],
            pin_in[port0_pkg::irq0_bit]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            converter_trigger_in <= 1'b0;
        end else begin
            converter_trigger_in <= next_converter_trigger_in;
        end
    end

    // pin 4 feeds interrupt 1
    always_comb begin
        next_ext_irq_in_1 = routed(
            port_alt_mode_select[port0_pkg::irq1_bit],
            pin_in[port0_pkg::irq1_bit]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_irq_in_1 <= 1'b0;
        end else begin
            ext_irq_in_1 <= next_ext_irq_in_1;
        end
    end

    // pin 5 feeds interrupt 2 unless debug owns it
    always_comb begin
        next_ext_irq_in_2 = ~debug_enable_bit & routed(
            port_alt_mode_select[port0_pkg::irq2_bit],
            pin_in[port0_pkg::irq2_bit]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_irq_in_2 <= 1'b0;
        end else begin
            ext_irq_in_2 <= next_ext_irq_in_2;
        end
    end

    // pin 6 feeds interrupt 3
    always_comb begin
        next_ext_irq_in_3 = routed(
            port_alt_mode_select[port0_pkg::irq3_bit],
            pin_in[port0_pkg::irq3_bit]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_irq_in_3 <= 1'b0;
        end else begin
            ext_irq_in_3 <= next_ext_irq_in_3;
        end
    end

    // debug reset follows pin 5 whatever its mode bit
    always_comb begin
        next_debug_reset_in = debug_enable_bit &
            pin_in[port0_pkg::dbg_rst_bit];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            debug_reset_in <= 1'b0;
        end else begin
            debug_reset_in <= next_debug_reset_in;
        end
    end
endmodule
`default_nettype wire

// ===== dv/port0_pfc_sva.sv
// checker on port 0 pin function ports
`timescale 1ns/1ps
`default_nettype none
module port0_pfc_sva (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic       nmi_in,
    input wire logic       ext_irq_in_0,
    input wire logic       converter_trigger_in,
    input wire logic       ext_irq_in_1,
    input wire logic       ext_irq_in_2,
    input wire logic       ext_irq_in_3,
    input wire logic       debug_reset_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_spare; &{pin_oe_n[7], pin_oe_n[1:0]}; endproperty
    a_spare: assert property (p_spare) else $error("spare driven");
    property p_idle; !$past(rd) |-> rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("rdata without read");
    property p_rmask;
        rd |=> (rdata & ~port0_pkg::pin_mask) == 8'h00;
    endproperty
    a_rmask: assert property (p_rmask) else $error("spare bit read");
    property p_hold;
        !wr && !pin_oe_n[3] |=> !pin_oe_n[3] |-> $stable(pin_out[3]);
    endproperty
    a_hold: assert property (p_hold) else $error("latch moved");
    property p_drive;
        wr && addr == port0_pkg::data_off ##1 !pin_oe_n[4]
            |-> pin_out[4] == $past(wdata[4]);
    endproperty
    a_drive: assert property (p_drive) else $error("pin not latch");
    property p_nmi; nmi_in |-> $past(pin_in[2]); endproperty
    a_nmi: assert property (p_nmi) else $error("nmi not pin");
    property p_trig; ext_irq_in_0 == converter_trigger_in; endproperty
    a_trig: assert property (p_trig) else $error("trigger split");
    property p_irq1; ext_irq_in_1 |-> $past(pin_in[4]); endproperty
    a_irq1: assert property (p_irq1) else $error("irq1 not pin");
    property p_irq3; ext_irq_in_3 |-> $past(pin_in[6]); endproperty
    a_irq3: assert property (p_irq3) else $error("irq3 not pin");
    property p_dbg; !(debug_reset_in && ext_irq_in_2); endproperty
    a_dbg: assert property (p_dbg) else $error("pin 5 doubly used");
    c_rd: cover property (rd ##1 rdata != 8'h00);
    c_nmi: cover property (nmi_in);
    c_dbg: cover property (debug_reset_in);
endmodule
bind port0_pin_function_control port0_pfc_sva u_sva (.clk, .rst, .addr,
    .wdata, .wr, .rd, .rdata, .pin_in, .pin_out, .pin_oe_n, .nmi_in,
    .ext_irq_in_0, .converter_trigger_in, .ext_irq_in_1, .ext_irq_in_2,
    .ext_irq_in_3, .debug_reset_in);
`default_nettype wire

// ===== dv/pin_world.sv
// external pins: driven level or outside level
`timescale 1ns/1ps
`default_nettype none
module pin_world (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] ext,
    output logic      [7:0] pin_in
);
    assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
endmodule
`default_nettype wire

// ===== dv/tb_port0_pin_function_control.sv
// bench for port 0 pin function control
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_port0_pin_function_control;
    logic clk = 0, rst = 1, wr = 0, rd = 0;
    logic [2:0] addr = 0;
    logic [7:0] wdata = 0, ext = 0, rdata, pin_in, pin_out, pin_oe_n;
    logic nmi, i0, trg, i1, i2, i3, dr;
    int num_errors = 0, n_compared = 0, cyc = 0;
    always #2 clk = ~clk;
    port0_pin_function_control DUT (.clk, .rst, .addr, .wdata, .wr, .rd,
        .rdata, .pin_in, .pin_out, .pin_oe_n, .nmi_in(nmi),
        .ext_irq_in_0(i0), .converter_trigger_in(trg), .ext_irq_in_1(i1),
        .ext_irq_in_2(i2), .ext_irq_in_3(i3), .debug_reset_in(dr));
    pin_world world (.pin_out, .pin_oe_n, .ext, .pin_in);
    task automatic w(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk) begin wr <= 1; addr <= a; wdata <= d; end
        @(posedge clk) wr <= 0;
    endtask
    task automatic r(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk) begin rd <= 1; addr <= a; end
        @(posedge clk) rd <= 0;
        #1 `CHK("rdata", e, rdata)
    endtask
    task results;
        $display("compared %0d mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) if (++cyc == 3000) begin num_errors++; results; end
    task automatic test_reset;
        @(posedge clk) ext <= 8'h00;
        r(2, 8'h00);
        r(1, 8'h7c);
        `CHK("oe", 8'hff, pin_oe_n)
        $display("reset test done");
    endtask
    task automatic test_port;
        @(posedge clk) ext <= 8'h28;
        w(0, 8'h54);
        r(0, 8'h28);
        `CHK("oe", 8'hff, pin_oe_n)
        w(1, 8'h00);
        #1 `CHK("oe", 8'h83, pin_oe_n)
        `CHK("out", 8'h54, pin_out & 8'h7c)
        r(0, 8'h54);
        w(1, 8'h6c);
        #1 `CHK("out", 8'h10, pin_out & ~pin_oe_n)
        w(4, 8'h7c);
        #1 `CHK("oe", 8'hff, pin_oe_n)
        w(0, 8'h00);
        #1 `CHK("oe", 8'hef, pin_oe_n)
        w(4, 8'h00);
        $display("port test done");
    endtask
    task automatic test_alt;
        w(1, 8'hff);
        @(posedge clk) ext <= 8'h7c;
        w(3, 8'h08);
        r(3, 8'h08);
        w(2, 8'h7c);
        repeat (2) @(posedge clk);
        #1 `CHK("alt", 7'h7b, {nmi, i0, trg, i1, i2, i3, dr})
        r(0, 8'h7c);
        w(5, 8'h00);
        repeat (2) @(posedge clk);
        #1 `CHK("alt", 7'h7e, {nmi, i0, trg, i1, i2, i3, dr})
        $display("alternate test done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        test_reset;
        test_port;
        test_alt;
        results;
    end
endmodule
`default_nettype wire
